// [bcd_pair_counter.sv]
// two-digit bcd counter with load, min, max and carry
`timescale 1ns/1ps
module bcd_pair_counter #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic en_in,
    input wire logic step_in,
    input wire logic load_in,
    input wire logic [7:0] load_val_in,
    input wire logic [7:0] min_in,
    input wire logic [7:0] max_in,
    output logic [7:0] value_out,
    output logic wrap_out
);
    logic [7:0] next_value;

    // at or past the top the count returns to min; guards odd values
    assign wrap_out = step_in && (value_out >= max_in);
    assign next_value = load_in ? load_val_in :
                        wrap_out ? min_in :
                        step_in ? rtc_cal_pkg::bcd_up(value_out) : value_out;

    // software load wins over a count step in the same cycle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            value_out <= RST_VAL;
        end else if (en_in) begin
            value_out <= next_value;
        end
    end
endmodule // bcd_pair_counter

// [rtc_cal_pkg.sv]
// constants and helpers for the calendar counter block
package rtc_cal_pkg;
    // ---------------------------------------------
    // register offsets (byte registers)
    // ---------------------------------------------
    localparam logic [3:0] ADDR_CENTI = 4'h0;
    localparam logic [3:0] ADDR_SEC = 4'h1;
    localparam logic [3:0] ADDR_MIN = 4'h2;
    localparam logic [3:0] ADDR_HOUR = 4'h3;
    localparam logic [3:0] ADDR_DAY = 4'h4;
    localparam logic [3:0] ADDR_WDAY = 4'h5;
    localparam logic [3:0] ADDR_MONTH = 4'h6;
    localparam logic [3:0] ADDR_YEAR = 4'h7;
    localparam logic [3:0] ADDR_CTRL = 4'h8;
    localparam logic [3:0] ADDR_STAT = 4'h9;
    localparam logic [3:0] ADDR_MASK = 4'ha;
    // ---------------------------------------------
    // field positions
    // ---------------------------------------------
    localparam int OS_BIT = 7;
    localparam int EVENT_MONITOR_BIT_BIT = 7;
    localparam int HALF_DAY_BIT = 5;
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_CENTI_BIT = 1;
    localparam int CTRL_H12_BIT = 2;
    localparam int ST_SEC_BIT = 0;
    localparam int ST_MIN_BIT = 1;
    localparam int ST_OSC_BIT = 2;
    localparam int ST_W = 3;
    // ---------------------------------------------
    // write masks, reset values, ranges
    // ---------------------------------------------
    localparam logic [7:0] MASK_7 = 8'h7f;
    localparam logic [7:0] MASK_HOUR = 8'h3f;
    localparam logic [7:0] MASK_DAY = 8'h3f;
    localparam logic [7:0] MASK_MONTH = 8'h1f;
    localparam logic [7:0] MASK_CTRL = 8'h07;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ONE = 8'h01;
    localparam logic [2:0] RST_WDAY = 3'h6;
    localparam logic [7:0] RST_CTRL = 8'h02;
    localparam logic [7:0] MAX_99 = 8'h99;
    localparam logic [7:0] MAX_59 = 8'h59;
    localparam logic [7:0] MAX_MONTH = 8'h12;
    localparam logic [2:0] MAX_WDAY = 3'h6;
    localparam logic [5:0] H24_TOP = 6'h23;
    localparam logic [4:0] H12_TOP = 5'h12;
    localparam logic [4:0] H12_TURN = 5'h11;
    localparam logic [4:0] H12_FIRST = 5'h01;
    localparam logic [7:0] MON_FEB = 8'h02;
    localparam logic [7:0] MON_APR = 8'h04;
    localparam logic [7:0] MON_JUN = 8'h06;
    localparam logic [7:0] MON_SEP = 8'h09;
    localparam logic [7:0] MON_NOV = 8'h11;
    localparam logic [7:0] DAYS_31 = 8'h31;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_28 = 8'h28;

    // one decimal step of a two-digit bcd byte
    function automatic logic [7:0] bcd_up(input logic [7:0] v);
        bcd_up = (v[3:0] >= 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction
endpackage

// [rtc_time_date_counters.sv]
// calendar counting core with byte register port and interrupt
// How it works
// - counters run in calendar mode only while the mode select bit is 0
// - each register holds tens digit high and units digit low
// - digits count 0 to 9; software writes only valid digits
// - reset gives 00:00:00.00, 2000-01-01, saturday, stop flag 1, monitor 0
// - unimplemented bits read as zero
// - centisecond register reads zero while its enable is off
// - hour format bit picks 12 or 24 hours; bit 5 is half day
// - february gets a 29th day when year divides by four
// - oscillator stop flag in seconds bit 7 sets when oscillator stops
// - flag is set from power-on until oscillator runs
// - flag stays set until software clears it by write
// - clear attempt fails while oscillator is still stopped
// - monitor bit mirrors any set flag and cannot be cleared
// - a read of offset 0 copies registers 0 to 7 into a holding copy
// - weekday is a 3-bit code 0 to 6, meaning user-defined
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module rtc_time_date_counters (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    input wire logic tick_in,
    input wire logic osc_running_in,
    input wire logic [7:0] flags_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [7:0] rd_data_out,
    output logic irq_out
);
    // ---------------------------------------------
    // declarations
    // ---------------------------------------------
    logic tick_s;
    logic tick_d;
    logic osc_s;
    logic [7:0] ctrl;
    logic [7:0] centi;
    logic [7:0] sec;
    logic [7:0] minute;
    logic [5:0] hour;
    logic [5:0] next_hour;
    logic [7:0] day;
    logic [2:0] wday;
    logic [2:0] next_wday;
    logic [7:0] month;
    logic [7:0] year;
    logic os_flag;
    logic next_os_flag;
    logic event_monitor_bit;
    localparam int ST_W_L = rtc_cal_pkg::ST_W;
    logic [ST_W_L-1:0] stat;
    logic [ST_W_L-1:0] mask;
    logic [ST_W_L-1:0] next_stat;
    logic [7:0] snap [0:7];
    logic [7:0] live [0:7];
    logic h_carry;

    // ---------------------------------------------
    // pin inputs: tick and oscillator status
    // ---------------------------------------------
    sync2_flop u_tick_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .en_in(clk_en_in),
        .d_in(tick_in),
        .q_out(tick_s)
    );
    sync2_flop u_osc_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .en_in(clk_en_in),
        .d_in(osc_running_in),
        .q_out(osc_s)
    );

    // write decode, shared by every register
    function automatic logic hit(input logic [3:0] a);
        hit = wr_en_in && (addr_in == a);
    endfunction

    // ---------------------------------------------
    // decode of control bits and write strobes
    // ---------------------------------------------
    wire counter_mode_select = ctrl[rtc_cal_pkg::CTRL_MODE_BIT];
    wire centisecond_enable = ctrl[rtc_cal_pkg::CTRL_CENTI_BIT];
    wire hour_12_mode = ctrl[rtc_cal_pkg::CTRL_H12_BIT];
    wire tick_edge = tick_s & ~tick_d;
    wire run = tick_edge & ~counter_mode_select;
    wire wr_centi = hit(rtc_cal_pkg::ADDR_CENTI);
    wire wr_sec = hit(rtc_cal_pkg::ADDR_SEC);
    wire wr_min = hit(rtc_cal_pkg::ADDR_MIN);
    wire wr_hour = hit(rtc_cal_pkg::ADDR_HOUR);
    wire wr_day = hit(rtc_cal_pkg::ADDR_DAY);
    wire wr_wday = hit(rtc_cal_pkg::ADDR_WDAY);
    wire wr_month = hit(rtc_cal_pkg::ADDR_MONTH);
    wire wr_year = hit(rtc_cal_pkg::ADDR_YEAR);
    wire wr_ctrl = hit(rtc_cal_pkg::ADDR_CTRL);
    wire wr_stat = hit(rtc_cal_pkg::ADDR_STAT);
    wire wr_mask = hit(rtc_cal_pkg::ADDR_MASK);
    wire c_wrap;
    wire s_wrap;
    wire m_wrap;
    wire d_wrap;
    wire mo_wrap;

    // tick edge detector reads only the synchronised level
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tick_d <= 1'b0;
        end else if (clk_en_in) begin
            tick_d <= tick_s;
        end
    end

    // ---------------------------------------------
    // centiseconds, seconds, minutes
    // ---------------------------------------------
    // hundredths count on each tick edge while mode select is 0, as they prescale the seconds
    bcd_pair_counter #(.RST_VAL(rtc_cal_pkg::RST_ZERO)) u_centi (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .en_in(clk_en_in),
        .step_in(run),
        .load_in(wr_centi),
        .load_val_in(wr_data_in),
        .min_in(rtc_cal_pkg::RST_ZERO),
        .max_in(rtc_cal_pkg::MAX_99),
        .value_out(centi),
        .wrap_out(c_wrap)
    );
    wire [7:0] sec_field;
    assign sec = {os_flag, sec_field[6:0]};
    bcd_pair_counter #(.RST_VAL(rtc_cal_pkg::RST_ZERO)) u_sec (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .en_in(clk_en_in),
        .step_in(c_wrap),
        .load_in(wr_sec),
        .load_val_in(wr_data_in & rtc_cal_pkg::MASK_7),
        .min_in(rtc_cal_pkg::RST_ZERO),
        .max_in(rtc_cal_pkg::MAX_59),
        .value_out(sec_field),
        .wrap_out(s_wrap)
    );
    wire [7:0] min_field;
    assign minute = {event_monitor_bit, min_field[6:0]};
    bcd_pair_counter #(.RST_VAL(rtc_cal_pkg::RST_ZERO)) u_min (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .en_in(clk_en_in),
        .step_in(s_wrap),
        .load_in(wr_min),
        .load_val_in(wr_data_in & rtc_cal_pkg::MASK_7),
        .min_in(rtc_cal_pkg::RST_ZERO),
        .max_in(rtc_cal_pkg::MAX_59),
        .value_out(min_field),
        .wrap_out(m_wrap)
    );

    // ---------------------------------------------
    // hours, 12 or 24 hour
    // ---------------------------------------------
    wire [7:0] hour_up = rtc_cal_pkg::bcd_up({2'h0, hour});
    wire [7:0] hour_low_up = rtc_cal_pkg::bcd_up({3'h0, hour[4:0]});
    // 11 -> 12 flips the half day; the day advances at 11 pm -> 12 am
    always_comb begin
        next_hour = hour;
        h_carry = 1'b0;
        if (wr_hour) begin
            next_hour = wr_data_in[5:0] & rtc_cal_pkg::MASK_HOUR[5:0];
        end else if (m_wrap) begin
            if (hour_12_mode) begin
                if (hour[4:0] >= rtc_cal_pkg::H12_TOP) begin
                    next_hour = {hour[5], rtc_cal_pkg::H12_FIRST};
                end else if (hour[4:0] == rtc_cal_pkg::H12_TURN) begin
                    next_hour = {~hour[5], rtc_cal_pkg::H12_TOP};
                    h_carry = hour[5];
                end else begin
                    next_hour = {hour[5], hour_low_up[4:0]};
                end
            end else if (hour >= rtc_cal_pkg::H24_TOP) begin
                next_hour = rtc_cal_pkg::RST_ZERO[5:0];
                h_carry = 1'b1;
            end else begin
                next_hour = hour_up[5:0];
            end
        end
    end

    // weekday steps with the day and wraps after 6
    always_comb begin
        next_wday = wday;
        if (wr_wday) begin
            next_wday = wr_data_in[2:0];
        end else if (h_carry) begin
            next_wday = (wday >= rtc_cal_pkg::MAX_WDAY) ? 3'h0 : wday + 3'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hour <= rtc_cal_pkg::RST_ZERO[5:0];
            wday <= rtc_cal_pkg::RST_WDAY;
        end else if (clk_en_in) begin
            hour <= next_hour;
            wday <= next_wday;
        end
    end

    // ---------------------------------------------
    // days, months, years
    // ---------------------------------------------
    // bcd year divisible by four: units low bits equal {tens lsb, 0}
    wire leap = (year[1:0] == {year[4], 1'b0});
    wire short_month = (month == rtc_cal_pkg::MON_APR) || (month == rtc_cal_pkg::MON_JUN) ||
                       (month == rtc_cal_pkg::MON_SEP) || (month == rtc_cal_pkg::MON_NOV);
    wire [7:0] feb_days = leap ? rtc_cal_pkg::DAYS_29 : rtc_cal_pkg::DAYS_28;
    wire [7:0] month_days = (month == rtc_cal_pkg::MON_FEB) ? feb_days :
                            short_month ? rtc_cal_pkg::DAYS_30 : rtc_cal_pkg::DAYS_31;
    bcd_pair_counter #(.RST_VAL(rtc_cal_pkg::RST_ONE)) u_day (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .en_in(clk_en_in),
        .step_in(h_carry),
        .load_in(wr_day),
        .load_val_in(wr_data_in & rtc_cal_pkg::MASK_DAY),
        .min_in(rtc_cal_pkg::RST_ONE),
        .max_in(month_days),
        .value_out(day),
        .wrap_out(d_wrap)
    );
    bcd_pair_counter #(.RST_VAL(rtc_cal_pkg::RST_ONE)) u_month (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .en_in(clk_en_in),
        .step_in(d_wrap),
        .load_in(wr_month),
        .load_val_in(wr_data_in & rtc_cal_pkg::MASK_MONTH),
        .min_in(rtc_cal_pkg::RST_ONE),
        .max_in(rtc_cal_pkg::MAX_MONTH),
        .value_out(month),
        .wrap_out(mo_wrap)
    );
    // year 00 stands for 2000; the century is not kept
    bcd_pair_counter #(.RST_VAL(rtc_cal_pkg::RST_ZERO)) u_year (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .en_in(clk_en_in),
        .step_in(mo_wrap),
        .load_in(wr_year),
        .load_val_in(wr_data_in),
        .min_in(rtc_cal_pkg::RST_ZERO),
        .max_in(rtc_cal_pkg::MAX_99),
        .value_out(year),
        .wrap_out()
    );

    // ---------------------------------------------
    // oscillator stop flag and event monitor
    // ---------------------------------------------
    // a stopped oscillator wins over a clear in the same cycle
    assign next_os_flag = !osc_s ? 1'b1 :
                          (wr_sec && !wr_data_in[rtc_cal_pkg::OS_BIT]) ? 1'b0 : os_flag;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            os_flag <= 1'b1;
            event_monitor_bit <= 1'b0;
        end else if (clk_en_in) begin
            os_flag <= next_os_flag;
            event_monitor_bit <= |flags_in;
        end
    end

    // ---------------------------------------------
    // control, status and mask registers
    // ---------------------------------------------
    wire [ST_W_L-1:0] events = {~osc_s, m_wrap, s_wrap};
    wire [ST_W_L-1:0] clr = wr_stat ? wr_data_in[ST_W_L-1:0] : '0;
    assign next_stat = (stat & ~clr) | events;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl <= rtc_cal_pkg::RST_CTRL;
            stat <= '0;
            mask <= '0;
            irq_out <= 1'b0;
        end else if (clk_en_in) begin
            ctrl <= wr_ctrl ? (wr_data_in & rtc_cal_pkg::MASK_CTRL) : ctrl;
            stat <= next_stat;
            mask <= wr_mask ? wr_data_in[ST_W_L-1:0] : mask;
            irq_out <= |(stat & mask);
        end
    end

    // ---------------------------------------------
    // read path with holding copy
    // ---------------------------------------------
    wire [7:0] centi_rd = centisecond_enable ? centi : 8'h00;
    assign live[0] = centi_rd;
    assign live[1] = sec;
    assign live[2] = minute;
    assign live[3] = {2'h0, hour};
    assign live[4] = day;
    assign live[5] = {5'h00, wday};
    assign live[6] = month;
    assign live[7] = year;
    wire snap_take = rd_en_in && (addr_in == rtc_cal_pkg::ADDR_CENTI);
    wire [7:0] time_rd = snap_take ? live[0] : snap[addr_in[2:0]];
    wire [7:0] rd_mux = (addr_in <= rtc_cal_pkg::ADDR_YEAR) ? time_rd :
                        (addr_in == rtc_cal_pkg::ADDR_CTRL) ? ctrl :
                        (addr_in == rtc_cal_pkg::ADDR_STAT) ? {5'h00, stat} :
                        (addr_in == rtc_cal_pkg::ADDR_MASK) ? {5'h00, mask} : 8'h00;

    // reading offset 0 freezes 0..7 while counting carries on
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < 8; i++) begin
                snap[i] <= 8'h00;
            end
            rd_data_out <= 8'h00;
        end else if (clk_en_in) begin
            if (snap_take) begin
                for (int i = 0; i < 8; i++) begin
                    snap[i] <= live[i];
                end
            end
            rd_data_out <= rd_en_in ? rd_mux : 8'h00;
        end
    end

    // ---------------------------------------------
    // assertions and covers
    // ---------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    halt_in_stop_a: assert property (clk_en_in && counter_mode_select && !wr_en_in |=> $stable(centi))
        else $error("counters moved while halted");
    os_set_a: assert property (clk_en_in && !osc_s |=> os_flag)
        else $error("stop flag not set");
    os_hold_a: assert property (clk_en_in && os_flag && !wr_sec |=> os_flag)
        else $error("stop flag cleared by itself");
    os_clear_fail_a: assert property (clk_en_in && wr_sec && !osc_s |=> os_flag)
        else $error("stop flag cleared while stopped");
    event_monitor_bit_track_a: assert property (clk_en_in |=> event_monitor_bit == |$past(flags_in))
        else $error("monitor bit wrong");
    centi_zero_a: assert property (clk_en_in && snap_take && !centisecond_enable |=> rd_data_out == 8'h00)
        else $error("centiseconds read nonzero");
    wday_bits_a: assert property (clk_en_in && rd_en_in && addr_in == rtc_cal_pkg::ADDR_WDAY
        |=> rd_data_out[7:3] == 5'h00)
        else $error("reserved bits nonzero");
    half_day_a: assert property (clk_en_in && hour_12_mode && m_wrap && !wr_en_in &&
        hour[4:0] == rtc_cal_pkg::H12_TURN |=> hour[4:0] == rtc_cal_pkg::H12_TOP && hour[5] != $past(hour[5]))
        else $error("half day turn wrong");
    leap_day_a: assert property (clk_en_in && h_carry && !wr_en_in && leap && month == rtc_cal_pkg::MON_FEB &&
        day == rtc_cal_pkg::DAYS_28 |=> day == rtc_cal_pkg::DAYS_29)
        else $error("leap day missing");
    sec_carry_a: assert property (clk_en_in && c_wrap && !wr_en_in |=> !$stable(sec_field))
        else $error("second carry lost");

    wire leap_day_hit = h_carry && leap && month == rtc_cal_pkg::MON_FEB && day == rtc_cal_pkg::DAYS_28;
    centi_wrap_c: cover property (clk_en_in && c_wrap);
    leap_day_c: cover property (clk_en_in && leap_day_hit);
    os_clear_c: cover property (os_flag ##1 !os_flag);
    irq_c: cover property ($rose(irq_out));
endmodule // rtc_time_date_counters

// [rtc_time_date_counters_tb.sv]
// self-checking bench for the calendar counter block
`timescale 1ns/1ps
module rtc_time_date_counters_tb;
    logic clk_in, rst_b_in, clk_en_in, tick_in, osc_running_in, wr_en_in, rd_en_in, irq_out;
    logic fire, run, rd_seen;
    logic [7:0] flags_in, wr_data_in, rd_data_out, yr;
    logic [3:0] addr_in;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int n_tests = 0;
    int yv;

    rtc_time_date_counters uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
        .tick_in(tick_in), .osc_running_in(osc_running_in), .flags_in(flags_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
        .irq_out(irq_out));
    tick_source_model crystal (.clk_in(clk_in), .fire_in(fire), .run_in(run), .tick_out(tick_in),
        .osc_running_out(osc_running_in));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // ---------------------------------------------
    // bus tasks and comparison
    // ---------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        wr_en_in <= 1'b0;
        rd_en_in <= 1'b0;
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        rd_en_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr_in <= a;
        rd_en_in <= 1'b1;
        wr_en_in <= 1'b0;
        @(posedge clk_in);
    endtask
    // address 0 first so the rest come from one coherent copy
    task automatic rd_regs(input logic [63:0] e);
        for (int i = 0; i < 8; i++) rd(4'(i), e[8*i+:8]);
    endtask
    // load all eight counters, one tick, then read back and check events
    task automatic roll(input logic [63:0] w, input logic [63:0] e, input logic [7:0] st);
        for (int i = 0; i < 8; i++) wr(4'(i), w[8*i+:8]);
        wr(rtc_cal_pkg::ADDR_STAT, 8'h03);
        idle(1);
        fire <= 1'b1;
        @(posedge clk_in);
        fire <= 1'b0;
        idle(10);
        rd_regs(e);
        rd(rtc_cal_pkg::ADDR_STAT, st);
        idle(2);
        chk({7'h0, irq_out}, {7'h0, |st});
        wr(rtc_cal_pkg::ADDR_STAT, 8'h03);
        idle(3);
        chk({7'h0, irq_out}, 8'h00);
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // read answer stands only in the cycle after its strobe
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_seen <= 1'b0;
        end else begin
            if (rd_seen) chk(rd_data_out, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
            rd_seen <= rd_en_in;
        end
    end

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #50000;
        n_mismatch++;
        conclude();
    end

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        rst_b_in = 1'b0;
        clk_en_in = 1'b1;
        flags_in = 8'h00;
        addr_in = 4'h0;
        wr_data_in = 8'h00;
        wr_en_in = 1'b0;
        rd_en_in = 1'b0;
        fire = 1'b0;
        run = 1'b0;
        void'($urandom(93103));
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        idle(2);
        rd_regs(64'h00_01_06_01_00_00_80_00);
        rd(rtc_cal_pkg::ADDR_CTRL, 8'h02);
        rd(rtc_cal_pkg::ADDR_STAT, 8'h04);
        rd(4'hb, 8'h00);
        idle(2);
        chk({7'h0, irq_out}, 8'h00);
        done("reset");
        // clearing the stop flag fails until the oscillator runs
        wr(rtc_cal_pkg::ADDR_SEC, 8'h00);
        rd(4'h0, 8'h00);
        rd(rtc_cal_pkg::ADDR_SEC, 8'h80);
        wr(rtc_cal_pkg::ADDR_MASK, 8'h04);
        idle(3);
        chk({7'h0, irq_out}, 8'h01);
        run <= 1'b1;
        idle(6);
        wr(rtc_cal_pkg::ADDR_STAT, 8'h04);
        wr(rtc_cal_pkg::ADDR_SEC, 8'h00);
        rd(4'h0, 8'h00);
        rd(rtc_cal_pkg::ADDR_SEC, 8'h00);
        rd(rtc_cal_pkg::ADDR_STAT, 8'h00);
        idle(3);
        chk({7'h0, irq_out}, 8'h00);
        done("oscillator stop");
        // monitor bit follows any flag and ignores writes
        flags_in <= 8'($urandom_range(255, 1));
        idle(3);
        rd(4'h0, 8'h00);
        rd(rtc_cal_pkg::ADDR_MIN, 8'h80);
        wr(rtc_cal_pkg::ADDR_MIN, 8'h00);
        rd(4'h0, 8'h00);
        rd(rtc_cal_pkg::ADDR_MIN, 8'h80);
        flags_in <= 8'h00;
        wr(rtc_cal_pkg::ADDR_MIN, 8'h80);
        idle(3);
        rd(4'h0, 8'h00);
        rd(rtc_cal_pkg::ADDR_MIN, 8'h00);
        done("event monitor");
        wr(rtc_cal_pkg::ADDR_MASK, 8'h07);
        // halted counting, weekday upper bits dropped, centiseconds hidden
        wr(rtc_cal_pkg::ADDR_CTRL, 8'h03);
        roll(64'h99_12_fe_31_23_59_59_42, 64'h99_12_06_31_23_59_59_42, 8'h00);
        wr(rtc_cal_pkg::ADDR_CTRL, 8'h01);
        rd(4'h0, 8'h00);
        wr(rtc_cal_pkg::ADDR_CTRL, 8'h02);
        done("halt and centiseconds");
        // enable low freezes the synchroniser too, so this tick is lost
        clk_en_in <= 1'b0;
        fire <= 1'b1;
        @(posedge clk_in);
        fire <= 1'b0;
        idle(10);
        clk_en_in <= 1'b1;
        rd(4'h0, 8'h42);
        idle(2);
        done("clock enable");
        // calendar carries with a random leap year
        yv = $urandom_range(24, 0) * 4;
        yr = {4'(yv / 10), 4'(yv % 10)};
        roll({yr, 56'h02_06_28_23_59_59_99}, {yr, 56'h02_00_29_00_00_00_00}, 8'h03);
        roll({yr, 56'h02_03_29_23_59_59_99}, {yr, 56'h03_04_01_00_00_00_00}, 8'h03);
        yr = {4'((yv + 1) / 10), 4'((yv + 1) % 10)};
        roll({yr, 56'h02_02_28_23_59_59_99}, {yr, 56'h03_03_01_00_00_00_00}, 8'h03);
        roll({yr, 56'h04_01_30_23_59_59_99}, {yr, 56'h05_02_01_00_00_00_00}, 8'h03);
        roll(64'h99_12_05_31_23_59_59_99, 64'h00_01_06_01_00_00_00_00, 8'h03);
        done("calendar rollover");
        // twelve hour mode with half day bit
        wr(rtc_cal_pkg::ADDR_CTRL, 8'h06);
        roll(64'h20_07_01_15_11_59_59_99, 64'h20_07_01_15_32_00_00_00, 8'h03);
        roll(64'h20_07_01_15_31_59_59_99, 64'h20_07_02_16_12_00_00_00, 8'h03);
        roll(64'h20_07_02_16_12_59_59_99, 64'h20_07_02_16_01_00_00_00, 8'h03);
        done("twelve hour");
        conclude();
    end
endmodule // rtc_time_date_counters_tb

// [sync2_flop.sv]
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
module sync2_flop (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic en_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta <= 1'b0;
            q_out <= 1'b0;
        end else if (en_in) begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule // sync2_flop

// [tick_source_model.sv]
// crystal side model: tick pulses on a fire request while hold is 0, and oscillator running level
`timescale 1ns/1ps
module tick_source_model (
    input wire logic clk_in,
    input wire logic fire_in,
    input wire logic run_in,
    output logic tick_out,
    output logic osc_running_out
);
    logic [2:0] hold = 3'h0;
    // ---------------------------------------------
    // tick pulse: two cycles high, refire only after hold drains
    // ---------------------------------------------
    // spacing keeps tick edges well apart so the synchroniser sees each one
    always @(posedge clk_in) begin
        if (fire_in && hold == 3'h0) begin
            hold <= 3'h5;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
    end
    // high while hold is 5 or 4, so one driver makes the two-cycle pulse
    assign tick_out = (hold > 3'h3);
    // oscillator counts as stopped until the bench declares it stable
    assign osc_running_out = run_in;
endmodule // tick_source_model
